// *** prbchk_top.sv ***
/*
  Pattern checker on the incoming sample path, with its APB register file
  and a level interrupt. Assumes DATA_IN and DATA_VALID come from logic on
  CLK_SYS, so they are used without synchronisers, and that the stream is
  sent most significant bit first.
*/
// Function
// - Control bit 6 reads one after a matching word, zero after a mismatch.
// - Polynomial select zero expects the sequence of x^7 + x^6 + 1.
// - Polynomial select one expects the sequence of x^15 + x^14 + 1.
// - Counter-clear bit one holds the error tally at zero; zero resumes counting.
// - Words are compared only while enable is one; enable resets to zero.
// - Error tally register bits 7 to 0 show the mismatch count, reset zero.
`timescale 1ns/10ps
`default_nettype none

// One bit of the serial check: predicts the bit from earlier received bits.
module prbchk_bit_stage #(
  parameter int HIST_W = 15
) (
  // History and error so far.
  input wire logic [HIST_W-1:0] hist_in,
  input wire logic err_in,
  // Polynomial choice and received bit.
  input wire logic poly_sel,
  input wire logic rx_bit,
  // History and error after this bit.
  output logic [HIST_W-1:0] hist_out,
  output logic err_out
);

  logic expect_bit;

  // The prediction uses received bits only, so the check locks on by itself.
  always_comb begin
    if (poly_sel) begin
      expect_bit = hist_in[prbchk_pkg::TAP15_A] ^ hist_in[prbchk_pkg::TAP15_B];
    end else begin
      expect_bit = hist_in[prbchk_pkg::TAP7_A] ^ hist_in[prbchk_pkg::TAP7_B];
    end
  end

  assign err_out = err_in | (expect_bit ^ rx_bit);
  assign hist_out = {hist_in[HIST_W-2:0], rx_bit};

endmodule

module prbchk_top #(
  parameter int DATA_W = 16
) (
  // Clock, reset and clock enable.
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CE,
  // Incoming sample stream.
  input wire logic [DATA_W-1:0] DATA_IN,
  input wire logic DATA_VALID,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt.
  output logic IRQ
);

  prbchk_pkg::prbchk_ctrl_t ctrl_reg, ctrl_next;
  logic [prbchk_pkg::HIST_W-1:0] hist_reg, hist_next;
  logic primed_reg, primed_next;
  logic match_reg, match_next;
  logic [7:0] tally_reg, tally_next;
  logic [prbchk_pkg::EV_W-1:0] istat_reg, istat_next;
  logic [prbchk_pkg::EV_W-1:0] imask_reg, imask_next;
  logic irq_reg, irq_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;

  logic word_err;
  logic [prbchk_pkg::HIST_W-1:0] word_hist;
  logic check_now;
  logic mismatch;
  logic wr_take;
  logic [prbchk_pkg::EV_W-1:0] ev_set;
  logic [prbchk_pkg::EV_W-1:0] ev_clr;
  logic addr_ok;

  logic [prbchk_pkg::HIST_W-1:0] stage_hist [0:DATA_W];
  logic stage_err [0:DATA_W];
  logic sel_ctrl;
  logic sel_tally;
  logic sel_istat;
  logic sel_imask;

  // Stage k checks DATA_IN bit DATA_W-1-k, so the earliest bit of the word goes first.
  assign stage_hist[0] = hist_reg;
  assign stage_err[0] = 1'b0;

  for (genvar k = 0; k < DATA_W; k++) begin : g_stage
    prbchk_bit_stage #(
      .HIST_W(prbchk_pkg::HIST_W)
    ) u_stage (
      .hist_in(stage_hist[k]),
      .err_in(stage_err[k]),
      .poly_sel(ctrl_reg.poly_sel),
      .rx_bit(DATA_IN[DATA_W-1-k]),
      .hist_out(stage_hist[k+1]),
      .err_out(stage_err[k+1])
    );
  end

  assign word_err = stage_err[DATA_W];
  assign word_hist = stage_hist[DATA_W];

  // The first word after enabling only fills the history, since it has no past.
  assign check_now = DATA_VALID && ctrl_reg.enable && primed_reg;
  assign mismatch = check_now && word_err;

  // History and priming.
  always_comb begin
    hist_next = hist_reg;
    primed_next = primed_reg;
    if (!ctrl_reg.enable) begin
      primed_next = 1'b0;
    end else if (DATA_VALID) begin
      hist_next = word_hist;
      primed_next = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      hist_reg <= prbchk_pkg::HIST_RESET;
      primed_reg <= 1'b0;
    end else if (CE) begin
      hist_reg <= hist_next;
      primed_reg <= primed_next;
    end
  end

  // The match flag keeps the verdict of the last checked word, even across a clear.
  always_comb begin
    match_next = match_reg;
    if (check_now) begin
      match_next = !word_err;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      match_reg <= 1'b0;
    end else if (CE) begin
      match_reg <= match_next;
    end
  end

  // Error tally: the clear acts as a level, so it wins over any mismatch.
  always_comb begin
    tally_next = tally_reg;
    if (ctrl_reg.counter_clear) begin
      tally_next = prbchk_pkg::TALLY_RESET;
    end else if (mismatch && tally_reg != prbchk_pkg::TALLY_MAX) begin
      tally_next = tally_reg + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      tally_reg <= prbchk_pkg::TALLY_RESET;
    end else if (CE) begin
      tally_reg <= tally_next;
    end
  end

  // APB address decode, one select per register.
  always_comb begin
    sel_ctrl = 1'b0;
    sel_tally = 1'b0;
    sel_istat = 1'b0;
    sel_imask = 1'b0;
    if (PADDR == prbchk_pkg::CTRL_ADDR) begin
      sel_ctrl = 1'b1;
    end else if (PADDR == prbchk_pkg::TALLY_ADDR) begin
      sel_tally = 1'b1;
    end else if (PADDR == prbchk_pkg::ISTAT_ADDR) begin
      sel_istat = 1'b1;
    end else if (PADDR == prbchk_pkg::IMASK_ADDR) begin
      sel_imask = 1'b1;
    end
  end

  assign addr_ok = sel_ctrl || sel_tally || sel_istat || sel_imask;

  // The access phase lasts two cycles; a write lands at the edge that samples PREADY high.
  assign wr_take = PSEL && PENABLE && pready_reg && PWRITE && PSTRB[0] && !pslverr_reg;

  // Bus answer: read data is latched once, so it cannot change while PREADY stands.
  always_comb begin
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (PSEL && PENABLE && !pready_reg) begin
      pready_next = 1'b1;
      pslverr_next = !addr_ok;
      prdata_next = prbchk_pkg::RDATA_ZERO;
      if (!PWRITE) begin
        if (sel_ctrl) begin
          prdata_next[prbchk_pkg::BIT_MATCH] = match_reg;
          prdata_next[prbchk_pkg::BIT_POLY] = ctrl_reg.poly_sel;
          prdata_next[prbchk_pkg::BIT_CLEAR] = ctrl_reg.counter_clear;
          prdata_next[prbchk_pkg::BIT_ENABLE] = ctrl_reg.enable;
        end else if (sel_tally) begin
          prdata_next[7:0] = tally_reg;
        end else if (sel_istat) begin
          prdata_next[prbchk_pkg::EV_W-1:0] = istat_reg;
        end else if (sel_imask) begin
          prdata_next[prbchk_pkg::EV_W-1:0] = imask_reg;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= prbchk_pkg::RDATA_ZERO;
    end else if (CE) begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Software-written control and mask registers; the tally is read-only.
  always_comb begin
    ctrl_next = ctrl_reg;
    imask_next = imask_reg;
    if (wr_take) begin
      if (sel_ctrl) begin
        ctrl_next.enable = PWDATA[prbchk_pkg::BIT_ENABLE];
        ctrl_next.counter_clear = PWDATA[prbchk_pkg::BIT_CLEAR];
        ctrl_next.poly_sel = PWDATA[prbchk_pkg::BIT_POLY];
      end else if (sel_imask) begin
        imask_next = PWDATA[prbchk_pkg::EV_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl_reg <= prbchk_pkg::CTRL_RESET;
      imask_reg <= prbchk_pkg::EV_RESET;
    end else if (CE) begin
      ctrl_reg <= ctrl_next;
      imask_reg <= imask_next;
    end
  end

  // Interrupt status and the level interrupt.
  always_comb begin
    ev_clr = prbchk_pkg::EV_RESET;
    if (wr_take && sel_istat) begin
      ev_clr = PWDATA[prbchk_pkg::EV_W-1:0];
    end
    ev_set = prbchk_pkg::EV_RESET;
    ev_set[prbchk_pkg::EV_MISMATCH] = mismatch;
    ev_set[prbchk_pkg::EV_MATCH_LOST] = mismatch && match_reg;
    ev_set[prbchk_pkg::EV_TALLY_FULL] = (tally_next == prbchk_pkg::TALLY_MAX) && (tally_reg != prbchk_pkg::TALLY_MAX);
    // A new event wins over a clear written in the same cycle, so no event is lost.
    istat_next = (istat_reg & ~ev_clr) | ev_set;
    irq_next = |(istat_reg & imask_reg);
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      istat_reg <= prbchk_pkg::EV_RESET;
      irq_reg <= 1'b0;
    end else if (CE) begin
      istat_reg <= istat_next;
      irq_reg <= irq_next;
    end
  end

  // Every output comes straight from a flip-flop.
  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign IRQ = irq_reg;

endmodule

`default_nettype wire

// *** prbchk_pkg.sv ***
/*
  Shared constants and types of the pattern checker: register indexes and
  byte addresses, field positions, reset values and the control carrier.
  Assumes registers are reached over APB with 32-bit data, one word each.
*/
package prbchk_pkg;

  // Register indexes; the byte address is four times the index.
  localparam logic [9:0] CTRL_IDX = 10'h14B;
  localparam logic [9:0] TALLY_IDX = 10'h14C;
  localparam logic [9:0] ISTAT_IDX = 10'h150;
  localparam logic [9:0] IMASK_IDX = 10'h151;
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [11:0] TALLY_ADDR = {TALLY_IDX, 2'b00};
  localparam logic [11:0] ISTAT_ADDR = {ISTAT_IDX, 2'b00};
  localparam logic [11:0] IMASK_ADDR = {IMASK_IDX, 2'b00};

  // Control register field positions.
  localparam int BIT_ENABLE = 0;
  localparam int BIT_CLEAR = 1;
  localparam int BIT_POLY = 2;
  localparam int BIT_MATCH = 6;

  // Interrupt status and mask field positions.
  localparam int EV_W = 3;
  localparam int EV_MISMATCH = 0;
  localparam int EV_MATCH_LOST = 1;
  localparam int EV_TALLY_FULL = 2;

  localparam logic [7:0] TALLY_RESET = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hFF;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // History depth: enough bits for the longer polynomial.
  localparam int HIST_W = 15;
  localparam logic [HIST_W-1:0] HIST_RESET = 15'h0000;

  // Tap positions into the history (index 0 is the newest bit).
  localparam int TAP7_A = 6;
  localparam int TAP7_B = 5;
  localparam int TAP15_A = 14;
  localparam int TAP15_B = 13;

  typedef struct packed {
    logic poly_sel;
    logic counter_clear;
    logic enable;
  } prbchk_ctrl_t;

  localparam prbchk_ctrl_t CTRL_RESET = '{poly_sel: 1'b0, counter_clear: 1'b0, enable: 1'b0};

endpackage

// *** prbchk_src.sv ***
/* Source of test pattern words, earliest bit in bit 15. Driven by the bench. */
`timescale 1ns/10ps
`default_nettype none
module prbchk_src (
  // Bench side and stream out.
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic poly,
  input wire logic flip,
  output logic [15:0] data,
  output logic valid
);
  logic [14:0] h, hn;
  logic [15:0] w;
  always_comb begin
    hn = h;
    for (int i = 15; i >= 0; i--) begin
      w[i] = poly ? hn[14] ^ hn[13] : hn[6] ^ hn[5];
      hn = {hn[13:0], w[i]};
    end
  end
  // Idle cycles show the inverted word, so a stale word never looks valid.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h <= 15'h7FFF;
      data <= 16'h0000;
      valid <= 1'h0;
    end else begin
      valid <= go;
      data <= go ? w ^ {flip, 15'h0000} : ~data;
      h <= go ? hn : h;
    end
  end
endmodule
`default_nettype wire

// *** prbchk_sva.sv ***
/* Assertions on the ports of prbchk_top. Assumes CE is held high. */
`timescale 1ns/10ps
`default_nettype none
module prbchk_sva (
  // Watched ports.
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic DATA_VALID,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  property p_rdy; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("late answer");
  property p_one; PREADY |=> !PREADY; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_ctl; PREADY && !PWRITE && PADDR == prbchk_pkg::CTRL_ADDR
    |-> PRDATA[31:7] == 0 && PRDATA[5:3] == 0 && !PSLVERR; endproperty
  a_ctl: assert property (p_ctl) else $error("control bits");
  property p_tly; PREADY && !PWRITE && PADDR == prbchk_pkg::TALLY_ADDR |-> PRDATA[31:8] == 0; endproperty
  a_tly: assert property (p_tly) else $error("tally width");
  property p_rst; $fell(RESET) |-> !IRQ && !PREADY; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_irq; !DATA_VALID && !PSEL |=> ##1 $stable(IRQ); endproperty
  a_irq: assert property (p_irq) else $error("irq moved");
endmodule
bind prbchk_top prbchk_sva SVA (.*);
`default_nettype wire

// *** tb_prbchk_top.sv ***
/* Bench of prbchk_top. Assumes CE and PSTRB tied high. */
`timescale 1ns/10ps
`default_nettype none
module tb_prbchk_top;
  localparam logic [11:0] CA = prbchk_pkg::CTRL_ADDR;
  localparam logic [11:0] TA = prbchk_pkg::TALLY_ADDR;
  localparam logic [11:0] SA = prbchk_pkg::ISTAT_ADDR;
  logic clk = 1'h0, rst = 1'h1, go = 1'h0, flip = 1'h0, mode = 1'h0;
  logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, dv, prdy, perr, irq;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, seed = 32'hF7DC15CB;
  logic [15:0] din;
  logic [32:0] exp_q[$];
  int failures = 0, tests_run = 0;
  always #20 clk = ~clk;
  prbchk_src SRC (.clk(clk), .rst(rst), .go(go), .poly(mode), .flip(flip), .data(din), .valid(dv));
  prbchk_top DUT (.CLK_SYS(clk), .RESET(rst), .CE(1'h1), .DATA_IN(din), .DATA_VALID(dv), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hF), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .IRQ(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  always @(posedge clk) begin
    if (prdy === 1'h1 && pwr === 1'h0) begin
      chk("read", exp_q.size() > 0 ? exp_q.pop_front() : 33'h1FFFFFFFF, {perr, prd});
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'h1 && n < 20);
    if (n >= 20) begin
      failures++;
      summarize();
    end
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [2:0] v);
    apb(1'h1, a, {seed[31:3], v});
  endtask
  task automatic words(input int n, input logic f);
    int k = 0;
    for (int j = 0; k < n && j < 9999; j++) begin
      @(posedge clk);
      seed = xs(seed);
      go <= seed[0];
      flip <= f;
      k += seed[0];
    end
    @(posedge clk);
    go <= 1'h0;
  endtask
  task automatic ick(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", {32'h0, e}, {32'h0, irq});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rd(CA, 33'h0);
    rd(TA, 33'h0);
    rd(12'h004, 33'h100000000);
    $display("reset test done");
    for (int p = 0; p < 2; p++) begin
      mode <= p[0];
      wr(CA, {p[0], 2'h1});
      words(20, 1'h0);
      rd(CA, p ? 33'h45 : 33'h41);
      words(1, 1'h1);
      rd(CA, p ? 33'h5 : 33'h1);
      rd(TA, 33'(p + 1));
    end
    $display("pattern test done");
    wr(CA, 3'h3);
    words(3, 1'h1);
    rd(TA, 33'h0);
    wr(CA, 3'h0);
    words(3, 1'h1);
    wr(CA, 3'h1);
    rd(TA, 33'h0);
    words(300, 1'h1);
    rd(TA, 33'hFF);
    wr(TA, 3'h0);
    rd(TA, 33'hFF);
    $display("count test done");
    rd(SA, 33'h7);
    ick(1'h0);
    wr(prbchk_pkg::IMASK_ADDR, 3'h1);
    ick(1'h1);
    wr(SA, 3'h1);
    ick(1'h0);
    rd(SA, 33'h6);
    $display("irq test done");
    summarize();
  end
endmodule
`default_nettype wire
